// File: hdl/thermal_limit_hysteresis_regs.sv
// register bank with fan-start and critical limit comparators and hysteresis
// ****************************************************************
// Summary of operation
// R1 - three fan-start registers, remote1/local/remote2, reset 0x5a (90 degC)
// R2 - above fan-start temperature the fan runs at minimum duty, ramping with span
// R3 - with lock set, fan-start, critical, xor and offset writes are ignored
// R4 - any channel above its critical limit forces every pwm output to full duty
// R5 - one critical limit register per channel, reset 0x64 (100 degC)
// R6 - critical limit value 0x80 disables forced full duty for that channel
// R7 - full duty holds until temperature falls below limit minus hysteresis
// R8 - overtemp pin, as output, pulls low at 0.25 degC above critical limit; code pulls low from 0.5 degC above
// R9 - 4-bit hysteresis; remote1/local share 0x44 reset, remote2 own at 0x40
// R10 - below fan-start, minimum duty holds until threshold minus hysteresis
// R11 - hysteresis spans zero to 15 degC per channel
// R12 - one hysteresis value serves both critical release and fan-start
// R13 - software should keep hysteresis at 4 degC or more
// R14 - bit 0 of xor test register enters xor tree mode; reset 0x00
// R15 - software leaves unused xor register bits 7 to 1 alone
// R16 - local offset: signed 8-bit, 0.25 degC per lsb, reset zero
// R17 - remote1 offset register, reset zero, corrects that channel reading
// R18 - hysteresis nibbles are whole degrees; remote1 upper, local lower nibble
// R19 - compare offset-corrected readings, updated on each channel conversion; remote2 is compared uncorrected here
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none

module thermal_limit_hysteresis_regs (
   input  wire logic                                         mclk,
   input  wire logic                                         reset_n,
   input  wire thermal_limit_pkg::reg_req_t                  reg_req,
   output logic [7:0]                                        reg_rd_data,
   input  wire logic                                         config_lock,
   input  wire thermal_limit_pkg::chan_sample_t [2:0]        chan_sample,
   input  wire logic                                         overtemp_pin_is_output,
   input  wire logic                                         overtemp_pin_in,
   output logic                                              overtemp_pin_out,
   output logic                                              overtemp_pin_oe,
   output logic                                              overtemp_pin_seen_low,
   output logic [2:0]                                        fan_on,
   output logic [2:0][11:0]                                  fan_excess,
   output logic                                              force_full_duty,
   output logic                                              xor_test_en
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   // whole-degree signed byte to quarter degrees in compare width
   function automatic logic [thermal_limit_pkg::CMP_W-1:0] deg_to_q(input logic [7:0] d);
      deg_to_q = {{2{d[7]}}, d, 2'b00};
   endfunction

   // unsigned hysteresis nibble in whole degrees to quarter degrees
   function automatic logic [thermal_limit_pkg::CMP_W-1:0] hyst_to_q(input logic [3:0] h);
      hyst_to_q = {6'h00, h, 2'b00};
   endfunction

   // signed a > b in compare width
   function automatic logic gt_s(input logic [thermal_limit_pkg::CMP_W-1:0] a,
                                 input logic [thermal_limit_pkg::CMP_W-1:0] b);
      gt_s = $signed(a) > $signed(b);
   endfunction

   thermal_limit_pkg::state_t                              st;
   thermal_limit_pkg::state_t                              next_st;
   logic [2:0][thermal_limit_pkg::CMP_W-1:0]               corr;
   logic [2:0][thermal_limit_pkg::CMP_W-1:0]               start_q;
   logic [2:0][thermal_limit_pkg::CMP_W-1:0]               lim_q;
   logic [2:0][thermal_limit_pkg::CMP_W-1:0]               hyst_q;
   logic [2:0][7:0]                                        offset_sel;
   logic                                                   wr_ok;

   // ****************************************************************
   // per-channel corrected reading and thresholds
   // ****************************************************************
   // remote2 offset lives outside this bank, so that channel is uncorrected
   always_comb begin
      offset_sel[thermal_limit_pkg::CH_REMOTE1] = st.offset_r1;    // [R17]
      offset_sel[thermal_limit_pkg::CH_LOCAL]   = st.offset_local; // [R16]
      offset_sel[thermal_limit_pkg::CH_REMOTE2] = 8'h00;
      // remote1 upper nibble, local lower, remote2 upper of its own [R18] [R9] [R11]
      hyst_q[thermal_limit_pkg::CH_REMOTE1] = hyst_to_q(st.hyst_r1l[7:4]);
      hyst_q[thermal_limit_pkg::CH_LOCAL]   = hyst_to_q(st.hyst_r1l[3:0]);
      hyst_q[thermal_limit_pkg::CH_REMOTE2] = hyst_to_q(st.hyst_r2[7:4]);
      for (int c = 0; c < thermal_limit_pkg::NUM_CHAN; c++) begin
         // sign-extended reading plus sign-extended quarter-degree offset [R16] [R19]
         corr[c] = {{2{chan_sample[c].reading[9]}}, chan_sample[c].reading}
                 + {{4{offset_sel[c][7]}}, offset_sel[c]};
         start_q[c] = deg_to_q(st.fan_start[c]);
         lim_q[c]   = deg_to_q(st.crit_limit[c]);
      end
   end

   // writes to protected registers are dropped while locked
   assign wr_ok = reg_req.wr_en && !config_lock; // [R3]

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb begin
      next_st        = st;
      next_st.pin_s1 = overtemp_pin_in;
      next_st.pin_s2 = st.pin_s1;
      // register writes
      case (reg_req.addr)
         thermal_limit_pkg::OFS_REMOTE1_FAN_START: begin
            if (wr_ok) next_st.fan_start[0] = reg_req.wdata; // [R1] [R3]
         end
         thermal_limit_pkg::OFS_LOCAL_FAN_START: begin
            if (wr_ok) next_st.fan_start[1] = reg_req.wdata; // [R1] [R3]
         end
         thermal_limit_pkg::OFS_REMOTE2_FAN_START: begin
            if (wr_ok) next_st.fan_start[2] = reg_req.wdata; // [R1] [R3]
         end
         thermal_limit_pkg::OFS_REMOTE1_CRIT: begin
            if (wr_ok) next_st.crit_limit[0] = reg_req.wdata; // [R5] [R3]
         end
         thermal_limit_pkg::OFS_LOCAL_CRIT: begin
            if (wr_ok) next_st.crit_limit[1] = reg_req.wdata; // [R5] [R3]
         end
         thermal_limit_pkg::OFS_REMOTE2_CRIT: begin
            if (wr_ok) next_st.crit_limit[2] = reg_req.wdata; // [R5] [R3]
         end
         // hysteresis stays writable under lock
         thermal_limit_pkg::OFS_REMOTE1_LOCAL_HYST: begin
            if (reg_req.wr_en) next_st.hyst_r1l = reg_req.wdata; // [R9]
         end
         thermal_limit_pkg::OFS_REMOTE2_HYST: begin
            if (reg_req.wr_en) next_st.hyst_r2 = reg_req.wdata; // [R9]
         end
         thermal_limit_pkg::OFS_XOR_TEST_ENABLE: begin
            // only the enable bit is kept, unused bits read zero [R14] [R3]
            if (wr_ok) next_st.xor_test_en = reg_req.wdata[thermal_limit_pkg::XOR_EN_BIT];
         end
         thermal_limit_pkg::OFS_REMOTE1_OFFSET: begin
            if (wr_ok) next_st.offset_r1 = reg_req.wdata; // [R17] [R3]
         end
         thermal_limit_pkg::OFS_LOCAL_OFFSET: begin
            if (wr_ok) next_st.offset_local = reg_req.wdata; // [R16] [R3]
         end
         default: begin
         end
      endcase
      // registered read data, unmapped reads give zero
      if (reg_req.rd_en) begin
         case (reg_req.addr)
            thermal_limit_pkg::OFS_REMOTE1_FAN_START:  next_st.rd_data = st.fan_start[0];
            thermal_limit_pkg::OFS_LOCAL_FAN_START:    next_st.rd_data = st.fan_start[1];
            thermal_limit_pkg::OFS_REMOTE2_FAN_START:  next_st.rd_data = st.fan_start[2];
            thermal_limit_pkg::OFS_REMOTE1_CRIT:       next_st.rd_data = st.crit_limit[0];
            thermal_limit_pkg::OFS_LOCAL_CRIT:         next_st.rd_data = st.crit_limit[1];
            thermal_limit_pkg::OFS_REMOTE2_CRIT:       next_st.rd_data = st.crit_limit[2];
            thermal_limit_pkg::OFS_REMOTE1_LOCAL_HYST: next_st.rd_data = st.hyst_r1l;
            thermal_limit_pkg::OFS_REMOTE2_HYST:       next_st.rd_data = st.hyst_r2;
            thermal_limit_pkg::OFS_XOR_TEST_ENABLE:    next_st.rd_data = {7'h00, st.xor_test_en};
            thermal_limit_pkg::OFS_REMOTE1_OFFSET:     next_st.rd_data = st.offset_r1;
            thermal_limit_pkg::OFS_LOCAL_OFFSET:       next_st.rd_data = st.offset_local;
            default:                                   next_st.rd_data = 8'h00;
         endcase
      end
      // comparators run only on a finished conversion of that channel [R19]
      for (int c = 0; c < thermal_limit_pkg::NUM_CHAN; c++) begin
         if (chan_sample[c].conv_done) begin
            // fan start with hysteresis band [R2] [R10] [R12]
            if (gt_s(corr[c], start_q[c])) begin
               next_st.fan_on[c] = 1'b1;
            end else if (!gt_s(corr[c], start_q[c] - hyst_q[c])) begin
               next_st.fan_on[c] = 1'b0;
            end
            // distance above fan start drives the duty ramp downstream [R2]
            next_st.excess[c] = gt_s(corr[c], start_q[c]) ? corr[c] - start_q[c] : '0;
            // critical entry, release below limit minus hysteresis [R4] [R7] [R12]
            if (st.crit_limit[c] == thermal_limit_pkg::CRIT_DISABLE) begin
               next_st.crit[c] = 1'b0; // [R6]
            end else if (gt_s(corr[c], lim_q[c])) begin
               next_st.crit[c] = 1'b1;
            end else if (gt_s(lim_q[c] - hyst_q[c], corr[c])) begin
               next_st.crit[c] = 1'b0;
            end
            // pin trip above one quarter degree beyond the limit, so from half a degree [R8] [R6]
            next_st.pin_trip[c] = (st.crit_limit[c] != thermal_limit_pkg::CRIT_DISABLE)
                               && gt_s(corr[c], lim_q[c] + 12'h001);
         end
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         st              <= '0;
         st.fan_start    <= {3{thermal_limit_pkg::RST_FAN_START}};  // [R1]
         st.crit_limit   <= {3{thermal_limit_pkg::RST_CRIT_LIMIT}}; // [R5]
         st.hyst_r1l     <= thermal_limit_pkg::RST_HYST_R1L;        // [R9]
         st.hyst_r2      <= thermal_limit_pkg::RST_HYST_R2;         // [R9]
         st.xor_test_en  <= thermal_limit_pkg::RST_XOR_TEST[thermal_limit_pkg::XOR_EN_BIT]; // [R14]
         st.offset_r1    <= thermal_limit_pkg::RST_TEMP_OFFSET;     // [R17]
         st.offset_local <= thermal_limit_pkg::RST_TEMP_OFFSET;     // [R16]
         st.pin_s1       <= 1'b1;
         st.pin_s2       <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign reg_rd_data           = st.rd_data;
   assign fan_on                = st.fan_on;
   assign fan_excess            = st.excess;
   assign force_full_duty       = |st.crit;                                // [R4]
   assign xor_test_en           = st.xor_test_en;                          // [R14]
   assign overtemp_pin_out      = 1'b0;                                    // open drain, low only
   assign overtemp_pin_oe       = overtemp_pin_is_output && (|st.pin_trip); // [R8]
   assign overtemp_pin_seen_low = !st.pin_s2;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   a_lock_fan_start: assert property ( // [R3]
      reg_req.wr_en && config_lock && reg_req.addr == thermal_limit_pkg::OFS_LOCAL_FAN_START
      |=> st.fan_start[1] == $past(st.fan_start[1]))
      else $error("locked fan start register changed");

   a_hyst_open_lock: assert property ( // [R9]
      reg_req.wr_en && reg_req.addr == thermal_limit_pkg::OFS_REMOTE1_LOCAL_HYST
      |=> st.hyst_r1l == $past(reg_req.wdata))
      else $error("hysteresis write lost");

   a_xor_bit_write: assert property ( // [R14]
      wr_ok && reg_req.addr == thermal_limit_pkg::OFS_XOR_TEST_ENABLE
      |=> xor_test_en == $past(reg_req.wdata[0]))
      else $error("xor test enable not taken");

   a_crit_entry: assert property ( // [R4]
      chan_sample[1].conv_done && gt_s(corr[1], lim_q[1])
      && st.crit_limit[1] != thermal_limit_pkg::CRIT_DISABLE |=> force_full_duty)
      else $error("critical excursion did not force full duty");

   a_crit_disable: assert property ( // [R6]
      chan_sample[0].conv_done && st.crit_limit[0] == thermal_limit_pkg::CRIT_DISABLE
      |=> !st.crit[0] && !st.pin_trip[0])
      else $error("disabled critical limit still acted");

   a_crit_hold: assert property ( // [R7]
      st.crit[1] && chan_sample[1].conv_done && !gt_s(lim_q[1] - hyst_q[1], corr[1])
      && st.crit_limit[1] != thermal_limit_pkg::CRIT_DISABLE |=> st.crit[1])
      else $error("critical released inside hysteresis");

   a_crit_release: assert property ( // [R7]
      st.crit[1] && chan_sample[1].conv_done && gt_s(lim_q[1] - hyst_q[1], corr[1])
      && !gt_s(corr[1], lim_q[1]) |=> !st.crit[1])
      else $error("critical not released below hysteresis");

   a_fan_start_hold: assert property ( // [R10]
      fan_on[2] && chan_sample[2].conv_done && gt_s(corr[2], start_q[2] - hyst_q[2])
      |=> fan_on[2])
      else $error("fan stopped inside hysteresis");

   a_fan_start_on: assert property ( // [R2]
      chan_sample[0].conv_done && gt_s(corr[0], start_q[0])
      |=> fan_on[0] && fan_excess[0] == $past(corr[0]) - $past(start_q[0]))
      else $error("fan not started above threshold");

   a_pin_drive: assert property ( // [R8]
      overtemp_pin_is_output && (|st.pin_trip) |-> overtemp_pin_oe && !overtemp_pin_out)
      else $error("overtemp pin not driven on trip");

   a_unmapped_read: assert property (
      reg_req.rd_en && (reg_req.addr < thermal_limit_pkg::OFS_REMOTE1_FAN_START
      || reg_req.addr > thermal_limit_pkg::OFS_LOCAL_OFFSET) |=> reg_rd_data == 8'h00)
      else $error("unmapped read not zero");

   a_fan_start_off: assert property ( // [R10]
      chan_sample[2].conv_done && !gt_s(corr[2], start_q[2] - hyst_q[2])
      |=> !fan_on[2])
      else $error("fan kept running below hysteresis band");

   a_lock_crit_limit: assert property ( // [R3]
      reg_req.wr_en && config_lock && reg_req.addr == thermal_limit_pkg::OFS_REMOTE2_CRIT
      |=> st.crit_limit[2] == $past(st.crit_limit[2]))
      else $error("locked critical limit changed");

   a_pin_trip_entry: assert property ( // [R8]
      chan_sample[0].conv_done && st.crit_limit[0] != thermal_limit_pkg::CRIT_DISABLE
      && gt_s(corr[0], lim_q[0] + 12'h001) |=> st.pin_trip[0])
      else $error("pin trip missed above limit");

   a_crit_any_chan: assert property ( // [R4]
      chan_sample[2].conv_done && gt_s(corr[2], lim_q[2])
      && st.crit_limit[2] != thermal_limit_pkg::CRIT_DISABLE |=> force_full_duty)
      else $error("remote2 excursion did not force full duty");

   c_crit_cycle: cover property (!force_full_duty ##1 force_full_duty [*2] ##[1:200] !force_full_duty);
   c_fan_start:  cover property (!fan_on[1] ##1 fan_on[1]);
   c_pin_trip:   cover property (overtemp_pin_oe);
   c_lock_write: cover property (reg_req.wr_en && config_lock);
   c_xor_mode:   cover property (!xor_test_en ##1 xor_test_en);

endmodule

`default_nettype wire

// File: hdl/thermal_limit_pkg.sv
// constants and carrier types for the thermal limit and hysteresis register bank
package thermal_limit_pkg;
   // ****************************************************************
   // register offsets
   // ****************************************************************
   localparam logic [7:0] OFS_REMOTE1_FAN_START  = 8'h67;
   localparam logic [7:0] OFS_LOCAL_FAN_START    = 8'h68;
   localparam logic [7:0] OFS_REMOTE2_FAN_START  = 8'h69;
   localparam logic [7:0] OFS_REMOTE1_CRIT       = 8'h6a;
   localparam logic [7:0] OFS_LOCAL_CRIT         = 8'h6b;
   localparam logic [7:0] OFS_REMOTE2_CRIT       = 8'h6c;
   localparam logic [7:0] OFS_REMOTE1_LOCAL_HYST = 8'h6d;
   localparam logic [7:0] OFS_REMOTE2_HYST       = 8'h6e;
   localparam logic [7:0] OFS_XOR_TEST_ENABLE    = 8'h6f;
   localparam logic [7:0] OFS_REMOTE1_OFFSET     = 8'h70;
   localparam logic [7:0] OFS_LOCAL_OFFSET       = 8'h71;

   // ****************************************************************
   // reset values, field positions, special codes
   // ****************************************************************
   localparam logic [7:0] RST_FAN_START    = 8'h5a;
   localparam logic [7:0] RST_CRIT_LIMIT   = 8'h64;
   localparam logic [7:0] RST_HYST_R1L     = 8'h44;
   localparam logic [7:0] RST_HYST_R2      = 8'h40;
   localparam logic [7:0] RST_XOR_TEST     = 8'h00;
   localparam logic [7:0] RST_TEMP_OFFSET  = 8'h00;
   localparam logic [7:0] CRIT_DISABLE     = 8'h80;
   localparam int         XOR_EN_BIT       = 0;
   localparam int         HYST_HI_LSB      = 4;
   localparam int         HYST_LO_LSB      = 0;
   localparam int         HYST_W           = 4;
   localparam int         NUM_CHAN         = 3;
   localparam int         CH_REMOTE1       = 0;
   localparam int         CH_LOCAL         = 1;
   localparam int         CH_REMOTE2       = 2;
   localparam int         TEMP_W           = 10; // signed, 0.25 degC per lsb
   localparam int         CMP_W            = 12; // widened compare domain

   // ****************************************************************
   // carrier types
   // ****************************************************************
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic              conv_done; // one-cycle pulse
      logic [TEMP_W-1:0] reading;   // raw conversion, signed quarter degrees
   } chan_sample_t;

   typedef struct packed {
      logic [NUM_CHAN-1:0][7:0]       fan_start;
      logic [NUM_CHAN-1:0][7:0]       crit_limit;
      logic [7:0]                     hyst_r1l;
      logic [7:0]                     hyst_r2;
      logic                           xor_test_en;
      logic [7:0]                     offset_r1;
      logic [7:0]                     offset_local;
      logic [NUM_CHAN-1:0]            fan_on;
      logic [NUM_CHAN-1:0]            crit;
      logic [NUM_CHAN-1:0]            pin_trip;
      logic [NUM_CHAN-1:0][CMP_W-1:0] excess;
      logic [7:0]                     rd_data;
      logic                           pin_s1;
      logic                           pin_s2;
   } state_t;
endpackage

// File: sim/tb.sv
// self-checking testbench for the thermal limit and hysteresis register bank
`timescale 1ns/10ps
`default_nettype none

module tb;
   // ****************************************************************
   // stimulus, design and bench model state
   // ****************************************************************
   logic                                  mclk;
   logic                                  reset_n;
   logic                                  config_lock;
   logic                                  pin_is_out;
   logic                                  pin_in;
   thermal_limit_pkg::reg_req_t           req;
   thermal_limit_pkg::chan_sample_t [2:0] smp;
   logic [7:0]                            rd_data;
   logic                                  pin_out;
   logic                                  pin_oe;
   logic                                  seen_low;
   logic                                  force_full;
   logic                                  xor_en;
   logic [2:0]                            fan_on;
   logic [2:0][11:0]                      excess;
   int                                    n_mismatch;
   int                                    checks;
   int                                    seed;
   logic [7:0]                            mreg [0:10];
   logic [2:0]                            m_fan;
   logic [2:0]                            m_crit;
   logic [2:0]                            m_trip;
   logic [11:0]                           m_exc [0:2];

   thermal_limit_hysteresis_regs i_thermal_limit_hysteresis_regs (
      .mclk                   (mclk),
      .reset_n                (reset_n),
      .reg_req                (req),
      .reg_rd_data            (rd_data),
      .config_lock            (config_lock),
      .chan_sample            (smp),
      .overtemp_pin_is_output (pin_is_out),
      .overtemp_pin_in        (pin_in),
      .overtemp_pin_out       (pin_out),
      .overtemp_pin_oe        (pin_oe),
      .overtemp_pin_seen_low  (seen_low),
      .fan_on                 (fan_on),
      .fan_excess             (excess),
      .force_full_duty        (force_full),
      .xor_test_en            (xor_en)
   );

   // 250 mhz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // ****************************************************************
   // compare tasks, expectation functions, bus and sample tasks
   // ****************************************************************
   task automatic miss(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      miss({4'h0, got}, {4'h0, exp});
   endtask
   task automatic chk_flag(input logic [2:0] got, input logic [2:0] exp);
      miss({9'h0, got}, {9'h0, exp});
   endtask
   task automatic chk_exc(input logic [11:0] got, input logic [11:0] exp);
      miss(got, exp);
   endtask

   function automatic logic [7:0] rst_val(input int i);
      if (i < 3) return thermal_limit_pkg::RST_FAN_START;
      if (i < 6) return thermal_limit_pkg::RST_CRIT_LIMIT;
      if (i == 6) return thermal_limit_pkg::RST_HYST_R1L;
      if (i == 7) return thermal_limit_pkg::RST_HYST_R2;
      return 8'h00;
   endfunction

   // write strobe for one cycle; model follows unlocked writes, and hysteresis writes even while locked
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      req.wr_en = 1'b1;
      req.addr  = a;
      req.wdata = d;
      @(negedge mclk);
      req.wr_en = 1'b0;
      if (a >= 8'h67 && a <= 8'h71 && !(config_lock && a != 8'h6d && a != 8'h6e))
         mreg[a - 8'h67] = (a == 8'h6f) ? {7'h00, d[0]} : d;
   endtask

   task automatic rd(input logic [7:0] a);
      logic [7:0] exp;
      @(negedge mclk);
      req.rd_en = 1'b1;
      req.addr  = a;
      @(negedge mclk);
      req.rd_en = 1'b0;
      @(negedge mclk);
      exp = (a >= 8'h67 && a <= 8'h71) ? mreg[a - 8'h67] : 8'h00;
      chk_reg(rd_data, exp);
      chk_flag({2'b00, xor_en}, {2'b00, mreg[8][0]});
   endtask

   // one conversion on channel c, then every flag checked against the model
   task automatic conv(input int c, input logic [9:0] r, input logic io);
      int corr;
      int s;
      int l;
      int h;
      @(negedge mclk);
      smp[c].conv_done = 1'b1;
      smp[c].reading   = r;
      pin_is_out       = io;
      corr = $signed(r);
      if (c < 2) corr = corr + $signed(mreg[9 + c]);
      s = 4 * $signed(mreg[c]);
      l = 4 * $signed(mreg[3 + c]);
      h = 4 * ((c == 0) ? mreg[6][7:4] : (c == 1) ? mreg[6][3:0] : mreg[7][7:4]);
      if (corr > s) m_fan[c] = 1'b1;
      else if (corr <= s - h) m_fan[c] = 1'b0;
      m_exc[c] = (corr > s) ? 12'(corr - s) : 12'h000;
      if (mreg[3 + c] == 8'h80) m_crit[c] = 1'b0;
      else if (corr > l) m_crit[c] = 1'b1;
      else if (corr < l - h) m_crit[c] = 1'b0;
      m_trip[c] = (mreg[3 + c] != 8'h80) && (corr > l + 1);
      @(negedge mclk);
      smp[c].conv_done = 1'b0;
      @(negedge mclk);
      chk_flag(fan_on, m_fan);
      chk_exc(excess[c], m_exc[c]);
      chk_flag({2'b00, force_full}, {2'b00, |m_crit});
      chk_flag({2'b00, pin_oe}, {2'b00, io & |m_trip});
   endtask

   task automatic give_verdict;
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // cut a hung run short
   initial begin
      #100000;
      n_mismatch++;
      give_verdict;
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [7:0] a;
      logic [7:0] d;
      int         c;
      int         base;
      seed = 17;
      reset_n = 1'b0;
      config_lock = 1'b0;
      pin_is_out = 1'b0;
      pin_in = 1'b1;
      req = '0;
      smp = '0;
      n_mismatch = 0;
      checks = 0;
      m_fan = 3'b000;
      m_crit = 3'b000;
      m_trip = 3'b000;
      for (int i = 0; i < 11; i++) mreg[i] = rst_val(i);
      for (int i = 0; i < 3; i++) m_exc[i] = 12'h000;
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      // reset values, unmapped places on both sides
      for (int i = 8'h66; i <= 8'h72; i++) rd(8'(i));
      chk_flag({2'b00, pin_out}, 3'b000);
      // local channel around critical limit, trip and release points
      conv(1, 10'd401, 1'b1);
      conv(1, 10'd402, 1'b1);
      conv(1, 10'd385, 1'b1);
      conv(1, 10'd383, 1'b1);
      conv(1, 10'd345, 1'b0);
      conv(1, 10'd344, 1'b0);
      wr(8'h6b, 8'h80);
      conv(1, 10'd500, 1'b1);
      wr(8'h6f, 8'h01);
      rd(8'h6f);
      // locked writes, hysteresis still open
      @(negedge mclk);
      config_lock = 1'b1;
      for (int i = 8'h67; i <= 8'h71; i++) wr(8'(i), (i == 8'h6f) ? 8'h01 : 8'h45);
      for (int i = 8'h67; i <= 8'h71; i++) rd(8'(i));
      config_lock = 1'b0;
      // random traffic around thresholds
      repeat (400) begin
         a = 8'h66 + 8'($random(seed) & 15);
         case ($random(seed) & 3)
            0: begin
               d = 8'($random(seed));
               if (a == 8'h6f) d = d & 8'h01;
               if (a == 8'h6d || a == 8'h6e) d = d | 8'h44;
               if (($random(seed) & 7) == 0) config_lock = ~config_lock;
               wr(a, d);
            end
            1: rd(a);
            default: begin
               c = $unsigned($random(seed)) % 3;
               base = ($random(seed) & 1) ? 4 * $signed(mreg[c]) : 4 * $signed(mreg[3 + c]);
               conv(c, 10'(base + $random(seed) % 40), 1'($random(seed)));
            end
         endcase
      end
      // pin level seen through the synchroniser
      pin_in = 1'b0;
      repeat (3) @(negedge mclk);
      chk_flag({2'b00, seen_low}, 3'b001);
      pin_in = 1'b1;
      repeat (3) @(negedge mclk);
      chk_flag({2'b00, seen_low}, 3'b000);
      give_verdict;
   end
endmodule

`default_nettype wire
